// ===== hdl/rtc_hours_century.sv
// hours and century stage of the timekeeping counter chain: live count,
// readable copy that lags after a supply switchover, byte register port
// assumes minute carry, year wrap and second tick pulses come
// from logic on i_clk, one cycle wide each; i_main_power is a level on i_clk
// limitation: the switchover lag is bounded by the second tick, not counted
// here, so a missing tick leaves the readable copy frozen except for host writes
//
// Contract
// - the century flag only moves while century tracking is enabled, or by a host write.
// - with tracking enabled, each year wrap from 99 to 00 inverts the century flag.
// - the tens-of-hours digit is BCD in 24-hour form with legal values 0 to 2.
// - the units-of-hours digit is BCD with legal values 0 to 9.
// - an out-of-range tens digit written by the host keeps counting until the next wrap; an out-of-range units digit folds to zero at the next hour.
// - after backup-to-main switchover the readable hours may lag up to one second.
// - the register sits at address 2 with enable, flag, tens and units at 7, 6, 5:4, 3:0.
`timescale 1ns/1ps
`default_nettype none

module rtc_hours_century (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire rtc_hours_pkg::reg_req_t i_req,
  input wire logic i_minute_carry,
  input wire logic i_year_wrap,
  input wire logic i_second_tick,
  input wire logic i_main_power,
  output var rtc_hours_pkg::hours_century_reg_t o_hours,
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  output logic o_hour_carry
);
  import rtc_hours_pkg::*;

  hours_century_reg_t live;
  hours_century_reg_t counted;
  hours_century_reg_t next_live;
  hours_century_reg_t shadow;
  hours_century_reg_t next_shadow;
  logic host_write;
  logic read_hit;
  logic day_wrap;
  logic next_hour_carry;
  logic on_main;
  logic switchover;
  logic stale;
  logic next_stale;
  logic [7:0] next_rdata;

  ////////////////////////////////////////////////////////////////////////////
  // field and decode helpers

  function automatic logic addr_hit(input logic [7:0] addr);
    return addr == HOURS_CENTURY_ADDR;
  endfunction

  // byte to fields by bit position, so the struct order cannot drift from the map
  function automatic hours_century_reg_t unpack_reg(input logic [7:0] b);
    hours_century_reg_t r;
    r.century_track_enable = b[CENTURY_TRACK_ENABLE_BIT];
    r.century_flag = b[CENTURY_FLAG_FLAG_BIT];
    r.hour_tens = b[HOUR_TENS_LSB +: 2];
    r.hour_units = b[HOUR_UNITS_LSB +: 4];
    return r;
  endfunction

  function automatic logic [7:0] pack_reg(input hours_century_reg_t r);
    logic [7:0] b;
    b = 8'h00;
    b[CENTURY_TRACK_ENABLE_BIT] = r.century_track_enable;
    b[CENTURY_FLAG_FLAG_BIT] = r.century_flag;
    b[HOUR_TENS_LSB +: 2] = r.hour_tens;
    b[HOUR_UNITS_LSB +: 4] = r.hour_units;
    return b;
  endfunction

  // 23 is the last hour; a bad tens digit never matches, so it runs on to 39
  function automatic logic is_last_hour(input hours_century_reg_t h);
    return (h.hour_tens == HOUR_TENS_MAX) && (h.hour_units == HOUR_UNITS_LAST);
  endfunction

  // one hour forward; a bad units digit folds to zero on its own rollover
  function automatic hours_century_reg_t advance_hour(input hours_century_reg_t h);
    hours_century_reg_t n;
    n = h;
    if (is_last_hour(h)) begin
      n.hour_tens = 2'h0;
      n.hour_units = 4'h0;
    end else if (h.hour_units >= HOUR_UNITS_MAX) begin
      n.hour_units = 4'h0;
      n.hour_tens = h.hour_tens + 2'h1;
    end else begin
      n.hour_units = h.hour_units + 4'h1;
    end
    return n;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // request decode

  assign host_write = i_req.wr && addr_hit(i_req.addr);
  assign read_hit = i_req.rd && addr_hit(i_req.addr);
  assign day_wrap = i_minute_carry && is_last_hour(live);

  ////////////////////////////////////////////////////////////////////////////
  // hour and century counting

  // count and century step, before any host write is laid over it
  always_comb begin
    counted = live;
    if (i_minute_carry) begin
      counted = advance_hour(live);
    end
    if (i_year_wrap && live.century_track_enable) begin
      counted.century_flag = ~live.century_flag;
    end
  end

  // host write wins over a same-cycle count, the host sees what it wrote
  assign next_live = host_write ? unpack_reg(i_req.wdata) : counted;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      live <= hours_century_reg_t'(HOURS_RESET);
    end else begin
      live <= next_live;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // day carry towards the day and date counters

  // a write over the last hour drops the carry, the day never saw 00
  assign next_hour_carry = day_wrap && !host_write;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_hour_carry <= 1'h0;
    end else begin
      o_hour_carry <= next_hour_carry;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // switchover detection; the readable copy waits for the next second tick

  assign switchover = i_main_power && !on_main;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      on_main <= 1'h0;
    end else begin
      on_main <= i_main_power;
    end
  end

  // a switchover wins over a tick in the same cycle, so the lag is never skipped
  always_comb begin
    next_stale = stale;
    if (switchover) begin
      next_stale = 1'h1;
    end else if (i_second_tick) begin
      next_stale = 1'h0;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      stale <= 1'h0;
    end else begin
      stale <= next_stale;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // readable copy

  // host writes refresh it at once so a read-back shows what was written
  always_comb begin
    next_shadow = shadow;
    if (host_write || !stale || i_second_tick) begin
      next_shadow = next_live;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      shadow <= hours_century_reg_t'(HOURS_RESET);
    end else begin
      shadow <= next_shadow;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_hours <= hours_century_reg_t'(HOURS_RESET);
    end else begin
      o_hours <= shadow;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read port

  assign next_rdata = read_hit ? pack_reg(shadow) : UNMAPPED_RDATA;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rvalid <= 1'h0;
    end else begin
      o_rvalid <= i_req.rd;
    end
  end

  // read data holds between reads
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= UNMAPPED_RDATA;
    end else if (i_req.rd) begin
      o_rdata <= next_rdata;
    end
  end

endmodule

`default_nettype wire

// ===== pkg/rtc_hours_pkg.sv
// package for the hours-and-century counter stage of the clock chain
// assumes one 100 MHz clock and a byte-wide register port from the serial engine
package rtc_hours_pkg;

  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned SETTLE_TIME_S = 1;
  localparam int unsigned SETTLE_CYCLES = SETTLE_TIME_S * CLK_HZ;

  localparam logic [7:0] HOURS_CENTURY_ADDR = 8'h02;
  localparam logic [7:0] UNMAPPED_RDATA = 8'h00;

  localparam int unsigned CENTURY_TRACK_ENABLE_BIT = 7;
  localparam int unsigned CENTURY_FLAG_FLAG_BIT = 6;
  localparam int unsigned HOUR_TENS_LSB = 4;
  localparam int unsigned HOUR_UNITS_LSB = 0;

  localparam logic [1:0] HOUR_TENS_MAX = 2'h2;
  localparam logic [3:0] HOUR_UNITS_MAX = 4'h9;
  localparam logic [3:0] HOUR_UNITS_LAST = 4'h3;

  localparam logic [7:0] HOURS_RESET = 8'h00;

  typedef struct packed {
    logic century_track_enable;
    logic century_flag;
    logic [1:0] hour_tens;
    logic [3:0] hour_units;
  } hours_century_reg_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

endpackage

// ===== tb/rtc_hours_host.sv
// host model driving the register port
// assumes requests begin after reset is released
`timescale 1ns/1ps
`default_nettype none
module rtc_hours_host (
  input wire logic i_clk,
  output var rtc_hours_pkg::reg_req_t o_req
);
  initial o_req = '0;
  // released lines show the inverse, so stale values never look valid
  task put(input logic w, input logic [7:0] a, d);
    @(posedge i_clk) o_req <= {w, !w, a, d};
    @(posedge i_clk) o_req <= {2'b00, ~a, ~d};
  endtask
endmodule
`default_nettype wire

// ===== tb/rtc_hours_century_properties.sv
// port checks for the hours and century stage
// assumes one clock, async active-high reset
`timescale 1ns/1ps
`default_nettype none
module rtc_hours_century_properties (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire rtc_hours_pkg::reg_req_t i_req,
  input wire logic i_minute_carry,
  input wire logic i_year_wrap,
  input wire logic i_main_power,
  input wire rtc_hours_pkg::hours_century_reg_t o_hours,
  input wire logic [7:0] o_rdata,
  input wire logic o_rvalid,
  input wire logic o_hour_carry
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // readable copy lags the count, so only trust it after a quiet cycle
  sequence settled;
    !$past(i_req.wr) && !$past(i_minute_carry) && !$past(i_year_wrap) && !i_req.wr && !i_main_power;
  endsequence
  a_read_answer: assert property (i_req.rd |=> o_rvalid) else $error("no rvalid");
  a_rvalid_cause: assert property (o_rvalid |-> $past(i_req.rd)) else $error("rvalid");
  a_unmapped_zero: assert property (i_req.rd && i_req.addr != rtc_hours_pkg::HOURS_CENTURY_ADDR
    |=> o_rdata == 8'h00)
    else $error("unmapped");
  a_carry_cause: assert property (o_hour_carry |-> $past(i_minute_carry)) else $error("carry");
  a_day_wrap: assert property (settled ##0 (i_minute_carry && o_hours[5:0] == 6'h23)
    |=> o_hour_carry ##1 o_hours[5:0] == 6'h00) else $error("wrap");
  a_units_roll: assert property (settled ##0 (i_minute_carry && o_hours[3:0] == 4'h9)
    |-> ##2 o_hours[3:0] == 4'h0) else $error("units");
  a_flag_toggle: assert property (settled ##0 (i_year_wrap && o_hours[7])
    |-> ##2 o_hours[6] != $past(o_hours[6], 2)) else $error("toggle");
  a_flag_hold: assert property (settled ##0 (i_year_wrap && !o_hours[7])
    |-> ##2 o_hours[6] == $past(o_hours[6], 2)) else $error("hold");
endmodule
bind rtc_hours_century rtc_hours_century_properties u_props (.i_clk, .i_rst, .i_req,
  .i_minute_carry, .i_year_wrap, .i_main_power, .o_hours, .o_rdata, .o_rvalid, .o_hour_carry);
`default_nettype wire

// ===== tb/rtc_hours_century_bench.sv
// bench for the hours and century stage
// assumes the host model owns the register port
`timescale 1ns/1ps
`default_nettype none
module rtc_hours_century_bench;
  import rtc_hours_pkg::*;
  logic i_clk = 0, i_rst = 1, mc = 0, yw = 0, st = 0, mp = 0, o_rvalid, o_hour_carry;
  reg_req_t req;
  hours_century_reg_t o_hours;
  logic [7:0] o_rdata;
  int errors = 0, n_compared = 0, cyc = 0;
  rtc_hours_host host (.i_clk, .o_req(req));
  rtc_hours_century DUT (.i_clk, .i_rst, .i_req(req), .i_minute_carry(mc), .i_year_wrap(yw),
    .i_second_tick(st), .i_main_power(mp), .o_hours, .o_rdata, .o_rvalid, .o_hour_carry);
  initial forever #5 i_clk = ~i_clk;
  always @(posedge i_clk) if (++cyc > 1000) begin
    errors++;
    wrap_up;
  end
  task chk(string n, logic [7:0] g, e);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task pulse(logic [2:0] m);
    @(posedge i_clk) {mc, yw, st} <= m;
    @(posedge i_clk) {mc, yw, st} <= 3'b000;
  endtask
  task rd(logic [7:0] a, e);
    host.put(0, a, 8'h00);
    #1 chk("rdata", o_rdata, e);
    chk("rvalid", {7'h00, o_rvalid}, 8'h01);
  endtask
  task t_regs;
    host.put(1, 8'h05, 8'h23);
    rd(8'h05, 8'h00);
    host.put(1, 8'h02, 8'hD3);
    rd(8'h02, 8'hD3);
  endtask
  task t_count;
    logic [15:0] tbl [4] = '{16'h2300, 16'h1920, 16'h0910, 16'h3C00};
    foreach (tbl[i]) begin
      host.put(1, 8'h02, tbl[i][15:8]);
      pulse(3'b100);
      #1 chk("carry", {7'h00, o_hour_carry}, {7'h00, tbl[i] == 16'h2300});
      @(posedge i_clk) #1 chk("hours", o_hours, tbl[i][7:0]);
    end
  endtask
  task t_century;
    for (int e = 0; e < 3; e++) begin
      host.put(1, 8'h02, {e != 0, e == 2, 6'h00});
      pulse(3'b010);
      @(posedge i_clk) #1 chk("flag", {7'h00, o_hours[6]}, {7'h00, e == 1});
    end
  endtask
  task t_switch;
    host.put(1, 8'h02, 8'h05);
    @(posedge i_clk) mp <= 1;
    repeat (2) @(posedge i_clk);
    pulse(3'b100);
    @(posedge i_clk) #1 chk("frozen", o_hours, 8'h05);
    rd(8'h02, 8'h05);
    pulse(3'b001);
    repeat (2) @(posedge i_clk);
    #1 chk("fresh", o_hours, 8'h06);
    rd(8'h02, 8'h06);
  endtask
  task wrap_up;
    if (errors == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge i_clk);
    i_rst <= 0;
    t_regs;
    t_count;
    t_century;
    t_switch;
    wrap_up;
  end
endmodule
`default_nettype wire
